/* File: rtl/cwg_top.sv */
// Purpose: Complementary waveform generator, four outputs
// Assumes: All inputs synchronous to mclk_i; control bits are
//          held by software-side registers outside this block
// Notes:   Outputs are registered, one clock after their cause
//
// Function
// - One selected input drives all waveforms
// - Per-output polarity bit, set means active-high
// - Polarity never touches override or steering
// - Two 6-bit counters, rising/reverse and falling/forward
// - Dead band counts clocks up to value
// - Half-bridge gap between true fall, inverted rise
// - Direction switches statics at next rising edge
// - Dead band only on first reversed pulse
// - Rising value delays A half, B full
// - Falling value delays B half, D full
// - Disabled: value writes load at once
// - Enabled: load request loads at falling edge
// - Too-short input gives no delayed pulse
// - Dead band accurate within one clock
// - Steering: steered follow input, others static
// - Polarity and shutdown act only on steered
// - Mode 000 applies steer bits immediately
// - Mode 001 applies steer bits on rise
// - Software shutdown holds while bit set
// - Auto-restart clears shutdown, resumes on rise
// - Active-low enabled sources force overrides
// - Shutdown not clearable while source active
// - Mode field decodes six modes, two reserved
// - Load request only once already enabled
// - Two level pairs set A/C and B/D
// - Full-bridge static and modulated output roles
// - Keeps running on its own clock
`timescale 1ns/100ps
`include "cwg_consts.svh"

module cwg_top (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic enable_i,
    input wire cwg_pkg::mode_type mode_i,
    input wire logic [`SEL_W-1:0] input_source_select_i,
    input wire logic remapped_input_pin_i,
    input wire logic [1:0] ccp_out_i,
    input wire logic [3:0] pwm_out_i,
    input wire logic oscillator_out_i,
    input wire logic comparator_one_result_i,
    input wire logic comparator_two_result_i,
    input wire logic [3:0] logic_cell_out_i,
    input wire logic timer_postscaled_tick_i,
    input wire logic shutdown_pin_i,
    input wire logic [`NOUT-1:0] output_invert_bit_i,
    input wire logic [`NOUT-1:0] output_steer_bit_i,
    input wire logic [`DB_W-1:0] rising_deadband_value_i,
    input wire logic [`DB_W-1:0] falling_deadband_value_i,
    input wire logic deadband_write_i,
    input wire logic buffer_load_request_i,
    input wire logic shutdown_set_i,
    input wire logic shutdown_clear_i,
    input wire logic auto_restart_i,
    input wire logic [`SEL_W-1:0] shutdown_source_select_i,
    input wire logic [1:0] override_level_first_pair_i,
    input wire logic [1:0] override_level_second_pair_i,
    output logic out_a_o,
    output logic out_b_o,
    output logic out_c_o,
    output logic out_d_o,
    output logic shutdown_o,
    output logic buffer_load_pending_o,
    output logic input_value_o
);
    import cwg_pkg::*;

    ctrl_state_type st_r;
    ctrl_state_type st_nxt;

    logic [`SRC_N-1:0] src_vec;
    logic [`SEL_W-1:0] sd_vec;
    logic in_s;
    logic sd_active;

    // ---------------------------------------------------------------
    // Input selection and shutdown sources
    // ---------------------------------------------------------------
    // Two spare codes read as a quiet low input
    assign src_vec = {`SRC_SPARE, logic_cell_out_i,
                      comparator_two_result_i, comparator_one_result_i,
                      oscillator_out_i, pwm_out_i, ccp_out_i,
                      remapped_input_pin_i};

    assign in_s = src_vec[input_source_select_i];

    assign sd_vec = {shutdown_pin_i, timer_postscaled_tick_i,
                     comparator_two_result_i, comparator_one_result_i};

    // Level sensitive, active low, gated by the source enables
    assign sd_active = |(shutdown_source_select_i & ~sd_vec);

    // ---------------------------------------------------------------
    // Dead-band counters
    // ---------------------------------------------------------------
    db_if dbi [`NDB] ();

    generate
        for (genvar g = 0; g < `NDB; g++) begin : g_db
            cwg_deadband u_db (
                .mclk_i(mclk_i),
                .rst_i(rst_i),
                .port(dbi[g].counter)
            );
        end
    endgenerate

    assign dbi[`DB_RISE].value = st_r.dbr;
    assign dbi[`DB_FALL].value = st_r.dbf;

    logic rise_ok;
    logic fall_ok;
    logic arm_rise;
    logic arm_fall;

    assign rise_ok = dbi[`DB_RISE].reached;
    assign fall_ok = dbi[`DB_FALL].reached;
    assign dbi[`DB_RISE].arm = arm_rise;
    assign dbi[`DB_FALL].arm = arm_fall;

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    logic rise;
    logic fall;
    logic steer_mode;
    logic full_mode;
    logic over_act;
    logic [`NOUT-1:0] mod_v;
    logic [`NOUT-1:0] ovr_v;

    assign rise = in_s & ~st_r.in_prev;
    assign fall = ~in_s & st_r.in_prev;

    always_comb begin
        st_nxt = st_r;
        st_nxt.en = enable_i;
        // Inputs treated as already in this clock domain
        st_nxt.in_prev = in_s;
        steer_mode = 1'b0;
        full_mode = 1'b0;
        arm_rise = 1'b0;
        arm_fall = 1'b0;
        mod_v = '0;
        ovr_v = '0;

        unique case (mode_i)
            MODE_STEER_ASYNC, MODE_STEER_SYNC: steer_mode = 1'b1;
            MODE_FULL_FWD, MODE_FULL_REV: full_mode = 1'b1;
            MODE_HALF, MODE_PUSH_PULL: steer_mode = 1'b0;
            MODE_RSVD_A, MODE_RSVD_B: steer_mode = 1'b0;
        endcase

        // Dead-band buffers
        if (!enable_i && deadband_write_i) begin
            st_nxt.dbr = rising_deadband_value_i;
            st_nxt.dbf = falling_deadband_value_i;
        end
        if (fall && st_r.ld && enable_i) begin
            st_nxt.dbr = rising_deadband_value_i;
            st_nxt.dbf = falling_deadband_value_i;
            st_nxt.ld = 1'b0;
        end
        if (!enable_i) begin
            st_nxt.ld = 1'b0;
        end
        // Request in the enabling write is ignored; set beats clear
        if (buffer_load_request_i && st_r.en && enable_i) begin
            st_nxt.ld = 1'b1;
        end

        // Steering update
        if (mode_i == MODE_STEER_SYNC) begin
            if (rise) begin
                st_nxt.steer = output_steer_bit_i;
            end
        end else begin
            st_nxt.steer = output_steer_bit_i;
        end

        // Full-bridge direction, latched on a rising input
        if (!full_mode || !enable_i) begin
            st_nxt.dir = mode_i[`MODE_DIR_BIT];
            st_nxt.first = 1'b0;
        end else if (rise) begin
            st_nxt.dir = mode_i[`MODE_DIR_BIT];
            if (mode_i[`MODE_DIR_BIT] != st_r.dir) begin
                st_nxt.first = 1'b1;
            end
        end else if (fall) begin
            st_nxt.first = 1'b0;
        end

        // Shutdown; a set in the same cycle as a clear wins
        if (shutdown_clear_i && !sd_active) begin
            st_nxt.shut = 1'b0;
        end
        if (auto_restart_i && !sd_active && !shutdown_set_i) begin
            st_nxt.shut = 1'b0;
        end
        if (shutdown_set_i || sd_active) begin
            st_nxt.shut = 1'b1;
        end
        // Overrides stay until the first rise after the clear
        if (st_nxt.shut) begin
            st_nxt.hold = 1'b1;
        end else if (rise) begin
            st_nxt.hold = 1'b0;
        end
        over_act = st_nxt.shut | st_nxt.hold;

        // Push-pull sequencer: first pulse on A
        if (!enable_i || over_act) begin
            st_nxt.pp = 1'b0;
        end else if (fall && mode_i == MODE_PUSH_PULL) begin
            st_nxt.pp = ~st_r.pp;
        end

        // Active-high modulated levels before polarity
        unique case (mode_i)
            MODE_STEER_ASYNC, MODE_STEER_SYNC: begin
                mod_v = {`NOUT{in_s}};
            end
            MODE_FULL_FWD, MODE_FULL_REV: begin
                if (!st_nxt.dir) begin
                    arm_fall = in_s & st_nxt.first;
                    mod_v[`OUT_A] = 1'b1;
                    mod_v[`OUT_D] = st_nxt.first ?
                                    (arm_fall & fall_ok) : in_s;
                end else begin
                    arm_rise = in_s & st_nxt.first;
                    mod_v[`OUT_C] = 1'b1;
                    mod_v[`OUT_B] = st_nxt.first ?
                                    (arm_rise & rise_ok) : in_s;
                end
            end
            MODE_HALF: begin
                arm_rise = in_s;
                arm_fall = ~in_s;
                // Each side waits out its count after the other drops
                mod_v[`OUT_A] = arm_rise & rise_ok;
                mod_v[`OUT_B] = arm_fall & fall_ok;
                mod_v[`OUT_C] = mod_v[`OUT_A];
                mod_v[`OUT_D] = mod_v[`OUT_B];
            end
            MODE_PUSH_PULL: begin
                mod_v[`OUT_A] = in_s & ~st_nxt.pp;
                mod_v[`OUT_B] = in_s & st_nxt.pp;
                mod_v[`OUT_C] = mod_v[`OUT_A];
                mod_v[`OUT_D] = mod_v[`OUT_B];
            end
            MODE_RSVD_A, MODE_RSVD_B: begin
                mod_v = '0;
            end
        endcase

        ovr_v[`OUT_A] = override_level_first_pair_i[`PAIR_LO];
        ovr_v[`OUT_C] = override_level_first_pair_i[`PAIR_HI];
        ovr_v[`OUT_B] = override_level_second_pair_i[`PAIR_LO];
        ovr_v[`OUT_D] = override_level_second_pair_i[`PAIR_HI];

        for (int i = 0; i < `NOUT; i++) begin
            if (!enable_i) begin
                st_nxt.outs[i] = 1'b0;
            end else if (steer_mode && !st_nxt.steer[i]) begin
                // Unsteered pins ignore polarity and shutdown
                st_nxt.outs[i] = 1'b0;
            end else if (over_act) begin
                st_nxt.outs[i] = ovr_v[i];
            end else begin
                st_nxt.outs[i] = output_invert_bit_i[i] ?
                                 mod_v[i] : ~mod_v[i];
            end
        end
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    // No gating here: runs on any clock chosen upstream, also in sleep
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign out_a_o = st_r.outs[`OUT_A];
    assign out_b_o = st_r.outs[`OUT_B];
    assign out_c_o = st_r.outs[`OUT_C];
    assign out_d_o = st_r.outs[`OUT_D];
    assign shutdown_o = st_r.shut;
    assign buffer_load_pending_o = st_r.ld;
    assign input_value_o = st_r.in_prev;

endmodule // cwg_top

/* File: pkg/cwg_consts.svh */
// Purpose: Named constants for the complementary waveform generator
// Assumes: Included by the package and the design modules
// Notes:   Definitions only
`ifndef CWG_CONSTS_SVH
`define CWG_CONSTS_SVH

`define DB_W 6
`define MODE_W 3
`define SEL_W 4
`define SRC_N 16
`define NOUT 4
`define NDB 2
`define DB_RISE 0
`define DB_FALL 1
`define OUT_A 0
`define OUT_B 1
`define OUT_C 2
`define OUT_D 3
`define PAIR_LO 0
`define PAIR_HI 1
`define MODE_DIR_BIT 0
`define DB_ONE 6'h01
`define DB_RST 6'h00
`define SRC_SPARE 2'h0

`endif

/* File: pkg/cwg_pkg.sv */
// Purpose: Types shared by the waveform generator modules
// Assumes: cwg_consts.svh supplies widths
// Notes:   Mode codes follow the three-bit mode field
`include "cwg_consts.svh"

package cwg_pkg;

    typedef enum logic [`MODE_W-1:0] {
        MODE_STEER_ASYNC = 3'b000,
        MODE_STEER_SYNC = 3'b001,
        MODE_FULL_FWD = 3'b010,
        MODE_FULL_REV = 3'b011,
        MODE_HALF = 3'b100,
        MODE_PUSH_PULL = 3'b101,
        MODE_RSVD_A = 3'b110,
        MODE_RSVD_B = 3'b111
    } mode_type;

    typedef struct packed {
        logic en;
        logic in_prev;
        logic shut;
        logic hold;
        logic ld;
        logic [`DB_W-1:0] dbr;
        logic [`DB_W-1:0] dbf;
        logic [`NOUT-1:0] steer;
        logic dir;
        logic first;
        logic pp;
        logic [`NOUT-1:0] outs;
    } ctrl_state_type;

    typedef struct packed {
        logic [`DB_W-1:0] cnt;
    } db_state_type;

endpackage

/* File: pkg/db_if.sv */
// Purpose: Link between the main logic and one dead-band counter
// Assumes: Single clock domain
// Notes:   reached is a pure function of counter state and value
`timescale 1ns/100ps
`include "cwg_consts.svh"

interface db_if;
    logic arm;
    logic [`DB_W-1:0] value;
    logic reached;
    modport counter (input arm, input value, output reached);
    modport user (output arm, output value, input reached);
endinterface

/* File: rtl/cwg_deadband.sv */
// Purpose: One 6-bit dead-band counter
// Assumes: arm is a level from the owning module
// Notes:   Counts clock periods from zero while armed
`timescale 1ns/100ps
`include "cwg_consts.svh"

module cwg_deadband (
    input wire logic mclk_i,
    input wire logic rst_i,
    db_if.counter port
);
    import cwg_pkg::*;

    db_state_type st_r;
    db_state_type st_nxt;

    // ---------------------------------------------------------------
    // Counter
    // ---------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        if (!port.arm) begin
            st_nxt.cnt = `DB_RST;
        end else if (st_r.cnt < port.value) begin
            st_nxt.cnt = st_r.cnt + `DB_ONE;
        end
    end

    // Compare with >= so a value lowered mid-count cannot stall it
    assign port.reached = (st_r.cnt >= port.value);

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule // cwg_deadband

/* File: testbench/cwg_properties.sv */
// Purpose: Port-level checks for the waveform generator
// Assumes: Outputs update one clock after their cause
// Notes:   Bound into cwg_top by name
`timescale 1ns/100ps
module cwg_checker (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic enable_i,
    input wire cwg_pkg::mode_type mode_i,
    input wire logic comparator_one_result_i,
    input wire logic comparator_two_result_i,
    input wire logic timer_postscaled_tick_i,
    input wire logic shutdown_pin_i,
    input wire logic [3:0] output_invert_bit_i,
    input wire logic [3:0] output_steer_bit_i,
    input wire logic buffer_load_request_i,
    input wire logic shutdown_set_i,
    input wire logic shutdown_clear_i,
    input wire logic auto_restart_i,
    input wire logic [3:0] shutdown_source_select_i,
    input wire logic [1:0] override_level_first_pair_i,
    input wire logic [1:0] override_level_second_pair_i,
    input wire logic out_a_o,
    input wire logic out_b_o,
    input wire logic out_c_o,
    input wire logic shutdown_o,
    input wire logic buffer_load_pending_o,
    input wire logic input_value_o
);
    import cwg_pkg::*;
    // ----------------
    // Assertions
    // ----------------
    logic src_act;
    // Sources are active low
    assign src_act = |(shutdown_source_select_i & ~{shutdown_pin_i,
        timer_postscaled_tick_i, comparator_two_result_i, comparator_one_result_i});
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    AST_SRC_SHUT: assert property (enable_i && src_act |=> shutdown_o)
        else $error("shutdown source ignored");
    AST_SW_HOLD: assert property (enable_i && shutdown_o && !auto_restart_i
        && !shutdown_clear_i |=> shutdown_o) else $error("shutdown dropped");
    AST_AUTO_CLEAR: assert property (enable_i && shutdown_o && auto_restart_i
        && !src_act && !shutdown_set_i |=> !shutdown_o) else $error("no auto restart");
    AST_OVERRIDE: assert property ($past(enable_i) && shutdown_o
        && $past(mode_i[2:1]) != 2'b00 |-> {out_c_o, out_a_o}
        == $past(override_level_first_pair_i) && out_b_o
        == $past(override_level_second_pair_i[0])) else $error("bad override");
    AST_LOAD_SET: assert property (enable_i && $past(enable_i)
        && buffer_load_request_i |=> buffer_load_pending_o) else $error("load lost");
    AST_LOAD_REFUSE: assert property (!$past(enable_i) |=>
        !buffer_load_pending_o) else $error("load taken while off");
    AST_STEER_STATIC: assert property (enable_i && mode_i == MODE_STEER_ASYNC
        && !output_steer_bit_i[1] |=> !out_b_o) else $error("unsteered active");
    AST_STEER_FOLLOW: assert property ($past(enable_i && mode_i == MODE_STEER_ASYNC
        && output_steer_bit_i[2] && !shutdown_o && !src_act && !shutdown_set_i)
        |-> out_c_o == (input_value_o ~^ $past(output_invert_bit_i[2])))
        else $error("steered output wrong");
    AST_HALF_GAP: assert property ($past(enable_i && mode_i == MODE_HALF
        && (&output_invert_bit_i[1:0])) && !shutdown_o |-> !(out_a_o && out_b_o))
        else $error("half-bridge overlap");
    AST_LEAD_GAP: assert property ($rose(input_value_o) && $past(enable_i
        && mode_i == MODE_HALF && output_invert_bit_i[0]) |-> !out_a_o)
        else $error("leading edge not delayed");
endmodule // cwg_checker

bind cwg_top cwg_checker chk (.*);

/* File: testbench/pwm_source.sv */
// Purpose: Free-running pulse source feeding the modulating input
// Assumes: High and low spans in clocks less one, changed at will
// Notes:   Moves on the falling edge like the bench
`timescale 1ns/100ps
module pwm_source (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [5:0] high_i,
    input wire logic [5:0] low_i,
    output logic pwm_o
);
    logic [5:0] cnt_r;
    // Short spans give pulses shorter than the dead band
    always_ff @(negedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r <= 6'h00;
            pwm_o <= 1'b0;
        end else if (cnt_r >= (pwm_o ? high_i : low_i)) begin
            cnt_r <= 6'h00;
            pwm_o <= ~pwm_o;
        end else begin
            cnt_r <= cnt_r + 6'h01;
        end
    end
endmodule // pwm_source

/* File: testbench/tb_top.sv */
// Purpose: Self-checking bench for the waveform generator
// Assumes: Inputs change on the falling edge
// Notes:   Checks are queued and compared by a monitor
`timescale 1ns/100ps
module tb_top;
    import cwg_pkg::*;
    logic mclk_i = 1'b0, rst_i = 1'b1, enable_i = 1'b0;
    mode_type mode_i = MODE_STEER_ASYNC;
    logic [3:0] input_source_select_i = 4'h0, shutdown_source_select_i = 4'h0;
    logic [3:0] output_invert_bit_i = 4'hf, output_steer_bit_i = 4'h0;
    logic [13:0] v = 14'h0300;
    logic timer_postscaled_tick_i = 1'b1, shutdown_pin_i = 1'b1, part;
    logic [5:0] rising_deadband_value_i = 6'h00, falling_deadband_value_i = 6'h00;
    logic [5:0] ph = 6'h02, pl = 6'h04;
    logic deadband_write_i = 1'b0, buffer_load_request_i = 1'b0, auto_restart_i = 1'b0;
    logic shutdown_set_i = 1'b0, shutdown_clear_i = 1'b0;
    logic [1:0] override_level_first_pair_i = 2'h2, override_level_second_pair_i = 2'h1;
    logic remapped_input_pin_i, oscillator_out_i;
    logic comparator_one_result_i, comparator_two_result_i;
    logic [1:0] ccp_out_i;
    logic [3:0] pwm_out_i, logic_cell_out_i;
    logic out_a_o, out_b_o, out_c_o, out_d_o, shutdown_o, buffer_load_pending_o;
    logic input_value_o;
    int errors = 0, cmp_count = 0;
    logic [6:0] exp_q[$], msk_q[$];
    int dexp_q[$], dgot_q[$];
    event chk_ev;
    assign {logic_cell_out_i, comparator_two_result_i, comparator_one_result_i} = v[13:8];
    assign {oscillator_out_i, pwm_out_i, ccp_out_i, remapped_input_pin_i} = v[7:0];
    cwg_top dut (.*);
    pwm_source src (.mclk_i(mclk_i), .rst_i(rst_i), .high_i(ph), .low_i(pl), .pwm_o(part));
    initial forever #2 mclk_i = ~mclk_i;
    // ----------------
    // Checking
    // ----------------
    task automatic cmp_out(input logic [6:0] e, input logic [6:0] m);
        logic [6:0] g;
        g = {input_value_o, buffer_load_pending_o, shutdown_o, out_d_o, out_c_o,
            out_b_o, out_a_o} & m;
        cmp_count++;
        if (g !== (e & m)) begin
            errors++;
            $display("CHECK FAILED %0t outputs %b expected %b", $time, g, e & m);
        end
    endtask
    // One clock of slack for edge uncertainty
    task automatic cmp_delay(input int e, input int g);
        cmp_count++;
        if (g != e && g != e + 1) begin
            errors++;
            $display("CHECK FAILED %0t delay %0d expected %0d", $time, g, e);
        end
    endtask
    always @(chk_ev) begin
        while (exp_q.size() > 0) cmp_out(exp_q.pop_front(), msk_q.pop_front());
        while (dexp_q.size() > 0) cmp_delay(dexp_q.pop_front(), dgot_q.pop_front());
    end
    task automatic chk(input logic [6:0] e, input logic [6:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        ->chk_ev;
    endtask
    task automatic dly(input int e, input int g);
        dexp_q.push_back(e);
        dgot_q.push_back(g);
        ->chk_ev;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk_i);
    endtask
    task automatic meas(input int b, input int lim, output int d);
        d = 0;
        do begin
            cyc(1);
            d++;
        end while ((({out_d_o, out_c_o, out_b_o, out_a_o} >> b) & 4'h1) !== 4'h1 && d < lim);
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        #80000;
        errors++;
        $display("CHECK FAILED %0t watchdog expired", $time);
        summarize();
    end
    // ----------------
    // Tests
    // ----------------
    initial begin
        int n, m, n2, d;
        void'($urandom(32'h7b34));
        cyc(16);
        rst_i = 1'b0;
        enable_i = 1'b1;
        for (int s = 0; s < 16; s++) begin
            input_source_select_i = s[3:0];
            v = 14'($urandom) | 14'h0300;
            cyc(1);
            chk({(s < 14) && v[s % 14], 6'h00}, 7'h40);
        end
        $display("test source select done");
        input_source_select_i = 4'h3;
        repeat (12) begin
            output_steer_bit_i = 4'($urandom);
            output_invert_bit_i = 4'($urandom);
            v[3] = 1'($urandom);
            cyc(1);
            chk({3'h0, output_steer_bit_i & (output_invert_bit_i ~^ {4{v[3]}})}, 7'h0f);
        end
        mode_i = MODE_STEER_SYNC;
        output_invert_bit_i = 4'hf;
        output_steer_bit_i = 4'h0;
        v[3] = 1'b0;
        cyc(1);
        v[3] = 1'b1;
        cyc(2);
        output_steer_bit_i = 4'hf;
        cyc(2);
        chk(7'h00, 7'h0f);
        v[3] = 1'b0;
        cyc(1);
        v[3] = 1'b1;
        cyc(1);
        chk(7'h0f, 7'h0f);
        $display("test steering done");
        enable_i = 1'b0;
        n = 2 + $urandom % 20;
        m = 2 + $urandom % 20;
        n2 = n + 9;
        rising_deadband_value_i = n[5:0];
        falling_deadband_value_i = m[5:0];
        deadband_write_i = 1'b1;
        cyc(1);
        deadband_write_i = 1'b0;
        mode_i = MODE_HALF;
        v[3] = 1'b0;
        enable_i = 1'b1;
        cyc(30);
        v[3] = 1'b1;
        meas(0, 60, d);
        dly(n + 1, d);
        cyc(30);
        v[3] = 1'b0;
        meas(1, 60, d);
        dly(m + 1, d);
        cyc(30);
        v[3] = 1'b1;
        cyc(1);
        v[3] = 1'b0;
        meas(0, 20, d);
        dly(20, d);
        $display("test dead band done");
        enable_i = 1'b0;
        cyc(1);
        enable_i = 1'b1;
        buffer_load_request_i = 1'b1;
        cyc(1);
        buffer_load_request_i = 1'b0;
        cyc(1);
        chk(7'h00, 7'h20);
        rising_deadband_value_i = n2[5:0];
        deadband_write_i = 1'b1;
        buffer_load_request_i = 1'b1;
        cyc(1);
        deadband_write_i = 1'b0;
        buffer_load_request_i = 1'b0;
        chk(7'h20, 7'h20);
        cyc(30);
        v[3] = 1'b1;
        meas(0, 60, d);
        dly(n + 1, d);
        cyc(10);
        v[3] = 1'b0;
        cyc(1);
        chk(7'h00, 7'h20);
        cyc(30);
        v[3] = 1'b1;
        meas(0, 60, d);
        dly(n2 + 1, d);
        $display("test buffered load done");
        v[3] = 1'b0;
        mode_i = MODE_FULL_FWD;
        cyc(20);
        v[3] = 1'b1;
        cyc(2);
        chk(7'h09, 7'h0f);
        mode_i = MODE_FULL_REV;
        cyc(2);
        chk(7'h09, 7'h0f);
        v[3] = 1'b0;
        cyc(20);
        v[3] = 1'b1;
        meas(1, 60, d);
        dly(n2 + 1, d);
        chk(7'h06, 7'h0f);
        v[3] = 1'b0;
        cyc(20);
        v[3] = 1'b1;
        meas(1, 60, d);
        dly(1, d);
        mode_i = MODE_FULL_FWD;
        v[3] = 1'b0;
        cyc(20);
        v[3] = 1'b1;
        meas(3, 60, d);
        dly(m + 1, d);
        $display("test full bridge done");
        mode_i = MODE_HALF;
        output_invert_bit_i = 4'h0;
        v[3] = 1'b0;
        cyc(40);
        shutdown_set_i = 1'b1;
        cyc(1);
        shutdown_set_i = 1'b0;
        cyc(9);
        chk(7'h16, 7'h1f);
        shutdown_source_select_i = 4'h8;
        shutdown_pin_i = 1'b0;
        shutdown_clear_i = 1'b1;
        cyc(1);
        shutdown_clear_i = 1'b0;
        cyc(1);
        chk(7'h16, 7'h1f);
        shutdown_pin_i = 1'b1;
        shutdown_clear_i = 1'b1;
        cyc(1);
        shutdown_clear_i = 1'b0;
        cyc(2);
        chk(7'h06, 7'h1f);
        v[3] = 1'b1;
        cyc(70);
        chk(7'h0a, 7'h1f);
        auto_restart_i = 1'b1;
        for (int k = 0; k < 4; k++) begin
            shutdown_source_select_i = 4'(1 << k);
            {shutdown_pin_i, timer_postscaled_tick_i, v[9], v[8]} = ~4'(1 << k);
            cyc(1);
            chk(7'h10, 7'h10);
            {shutdown_pin_i, timer_postscaled_tick_i, v[9], v[8]} = 4'hf;
            cyc(2);
            chk(7'h00, 7'h10);
        end
        shutdown_set_i = 1'b1;
        cyc(1);
        shutdown_set_i = 1'b0;
        chk(7'h10, 7'h10);
        cyc(2);
        chk(7'h00, 7'h10);
        shutdown_source_select_i = 4'h0;
        auto_restart_i = 1'b0;
        v[3] = 1'b0;
        cyc(2);
        v[3] = 1'b1;
        cyc(2);
        $display("test shutdown done");
        repeat (40) begin
            mode_i = mode_type'(3'($urandom));
            output_steer_bit_i = 4'($urandom);
            output_invert_bit_i = 4'($urandom);
            ph = 6'($urandom % 12);
            pl = 6'($urandom % 12);
            repeat (60) begin
                v[3] = part;
                cyc(1);
            end
            if (mode_i[2:1] == 2'b11) chk({3'h0, ~output_invert_bit_i}, 7'h0f);
        end
        $display("test random modes done");
        cyc(2);
        summarize();
    end
endmodule // tb_top
